//--- logic/dss_status_word.sv
// drive state machine and status word builder for a fieldbus servo drive
// assumes control word frames arrive as a one-cycle valid strobe and that
// all status inputs are synchronous levels
//
// Contract
// - status word bits 0..3,5,6 report state; 4 voltage; 7,14,15 zero
// - bit 11 limit, bit 10 arrival, bit 9 remote
// - not ready 0000 bit6 clear; disabled bit6 set
// - ready 0001, switched on 0011, enabled 0111
// - quick stop 0111, reaction 1111, fault 1000
// - bit 13 position error; bit 8 abnormal stop
// - bit 12 per mode; bit 13 homing error
// - sync cycle 125us..20ms accepted, nominal 250us..10ms
// - control bits; fault reset on bit 7 rise
`timescale 1ns/1ps
module dss_status_word (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // control word frame
   input wire logic controlValid,
   input wire logic [15:0] controlWord,
   input wire logic [7:0] opMode,
   // drive conditions
   input wire logic faultActive,
   input wire logic voltagePresent,
   input wire logic posLimitActive,
   input wire logic posArrived,
   input wire logic remoteControl,
   input wire dss_pkg::dss_mode_flags_t modeFlags,
   // sync event
   input wire logic syncPulse,
   // status outputs
   output logic [15:0] statusWord,
   output dss_pkg::dss_state_t driveState,
   output dss_pkg::dss_sync_status_t syncStatus
);
   import dss_pkg::*;

   dss_state_t state_reg;
   dss_state_t state_next;
   logic [15:0] status_reg;
   logic [15:0] status_next;
   logic prevReset_reg;

   // ==========================================================
   // control word decode
   wire cwVoltage = controlWord[CW_VOLTAGE];
   wire cmdDisableVolt = controlValid && !cwVoltage;
   wire cmdQuickStop = controlValid && cwVoltage && !controlWord[CW_QUICK_STOP_N];
   wire cmdShutdown = controlValid && controlWord[2:0] == 3'h6;
   wire cmdSwitchOn = controlValid && controlWord[3:0] == 4'h7;
   wire cmdEnableOp = controlValid && controlWord[3:0] == 4'hf;
   wire cwResetBit = controlWord[CW_FAULT_RESET];
   wire faultResetEdge = controlValid && cwResetBit && !prevReset_reg;

   // last fault reset bit seen, for edge detection
   always_ff @(posedge core_clk) begin
      if (!rstn) prevReset_reg <= 1'b0;
      else if (controlValid) prevReset_reg <= cwResetBit;
   end

   // ==========================================================
   // drive state machine
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_NOT_READY: state_next = ST_ON_DISABLED;  // self-init done
         ST_ON_DISABLED: begin
            if (cmdShutdown) state_next = ST_READY;
         end
         ST_READY: begin
            if (cmdDisableVolt || cmdQuickStop) state_next = ST_ON_DISABLED;
            else if (cmdSwitchOn) state_next = ST_SWITCHED_ON;
         end
         ST_SWITCHED_ON: begin
            if (cmdDisableVolt || cmdQuickStop) state_next = ST_ON_DISABLED;
            else if (cmdShutdown) state_next = ST_READY;
            else if (cmdEnableOp) state_next = ST_OP_ENABLED;
         end
         ST_OP_ENABLED: begin
            if (cmdDisableVolt) state_next = ST_ON_DISABLED;
            else if (cmdQuickStop) state_next = ST_QUICK_STOP;
            else if (cmdShutdown) state_next = ST_READY;
            else if (cmdSwitchOn) state_next = ST_SWITCHED_ON;
         end
         ST_QUICK_STOP: begin
            if (cmdDisableVolt) state_next = ST_ON_DISABLED;
            else if (cmdEnableOp) state_next = ST_OP_ENABLED;
         end
         ST_FAULT_REACT: state_next = ST_FAULT;  // reaction takes one cycle
         ST_FAULT: begin
            if (faultResetEdge && !faultActive) state_next = ST_ON_DISABLED;
         end
         default: state_next = ST_NOT_READY;
      endcase
      // internal fault overrides any command
      if (faultActive && state_reg != ST_FAULT && state_reg != ST_FAULT_REACT)
         state_next = ST_FAULT_REACT;
   end

   // ==========================================================
   // status word from the next state, so code and state move together
   wire nxtOff = state_next == ST_NOT_READY || state_next == ST_ON_DISABLED;
   wire nxtRunning = state_next == ST_READY || state_next == ST_SWITCHED_ON ||
                     state_next == ST_OP_ENABLED;
   wire modePP = opMode == MODE_PP;
   wire modeHM = opMode == MODE_HM;
   wire modeCS = opMode == MODE_CSP || opMode == MODE_CSV || opMode == MODE_CST;
   wire bit8 = modeFlags.abnormalStop && (modePP || modeHM || opMode == MODE_CSP);
   wire bit12 = (opMode == MODE_PV && modeFlags.velocityZero) ||
                (modeHM && modeFlags.homingDone) ||
                (modeCS && modeFlags.followingValid);
   wire bit13 = (modePP && modeFlags.posErrTooLarge) ||
                (modeHM && modeFlags.homingError);

   // state code in bits 3..0
   logic [3:0] stateCode;
   always_comb begin
      case (state_next)
         ST_READY: stateCode = CODE_READY;
         ST_SWITCHED_ON: stateCode = CODE_SWITCHED_ON;
         ST_OP_ENABLED: stateCode = CODE_OP_ENABLED;
         ST_QUICK_STOP: stateCode = CODE_OP_ENABLED;
         ST_FAULT_REACT: stateCode = CODE_FAULT_REACT;
         ST_FAULT: stateCode = CODE_FAULT;
         default: stateCode = CODE_OFF;
      endcase
   end

   // assemble word; reserved bits stay zero
   always_comb begin
      status_next = STATUS_RESET;
      status_next[3:0] = stateCode;
      status_next[SW_VOLTAGE] = voltagePresent;
      status_next[SW_QUICK_STOP] = nxtRunning;
      status_next[SW_ON_DISABLED] = state_next == ST_ON_DISABLED;
      status_next[SW_MODE_LO] = bit8;
      status_next[SW_REMOTE] = remoteControl;
      status_next[SW_ARRIVED] = posArrived;
      status_next[SW_LIMIT] = posLimitActive;
      status_next[SW_MODE_12] = bit12;
      status_next[SW_MODE_13] = bit13;
   end

   // state and status registers
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_reg <= ST_NOT_READY;
         status_reg <= STATUS_RESET;
      end else begin
         state_reg <= state_next;
         status_reg <= status_next;
      end
   end
   assign statusWord = status_reg;
   assign driveState = state_reg;

   // ==========================================================
   // sync cycle check
   dss_sync_monitor u_sync (
      .core_clk(core_clk),
      .rstn(rstn),
      .syncPulse(syncPulse),
      .syncStatus(syncStatus)
   );

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   property p_disabled_code;
      driveState == ST_ON_DISABLED |-> statusWord[6] && statusWord[3:0] == CODE_OFF;
   endproperty
   a_disabled_code: assert property (p_disabled_code) else $error("disabled code");

   property p_enabled_code;
      driveState == ST_OP_ENABLED |-> statusWord[6:5] == 2'b01 && statusWord[3:0] == 4'h7;
   endproperty
   a_enabled_code: assert property (p_enabled_code) else $error("enabled code");

   property p_qs_fault_code;
      (driveState == ST_QUICK_STOP |-> statusWord[6:5] == 2'b00 && statusWord[3:0] == 4'h7)
      and (driveState == ST_FAULT |-> !statusWord[6] && statusWord[3:0] == 4'h8);
   endproperty
   a_qs_fault_code: assert property (p_qs_fault_code) else $error("fault code");

   property p_reserved;
      statusWord[7] == 1'b0 && statusWord[15:14] == 2'b00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_limit;
      posLimitActive |=> statusWord[11];
   endproperty
   a_limit: assert property (p_limit) else $error("limit bit missing");

   property p_remote;
      remoteControl ##1 remoteControl |-> statusWord[9] ##1 statusWord[9];
   endproperty
   a_remote: assert property (p_remote) else $error("remote bit missing");

   property p_fault_reset;
      driveState == ST_FAULT && faultResetEdge && !faultActive
      |=> driveState == ST_ON_DISABLED && statusWord[6];
   endproperty
   a_fault_reset: assert property (p_fault_reset) else $error("fault reset lost");

   property p_no_spontaneous;
      driveState == ST_SWITCHED_ON && !controlValid && !faultActive |=> $stable(driveState);
   endproperty
   a_no_spontaneous: assert property (p_no_spontaneous) else $error("state moved");

   property p_homing_done;
      opMode == MODE_HM && modeFlags.homingDone |=> statusWord[12];
   endproperty
   a_homing_done: assert property (p_homing_done) else $error("homing bit missing");

   property p_pp_error;
      opMode == MODE_PP && modeFlags.posErrTooLarge |=> statusWord[13];
   endproperty
   a_pp_error: assert property (p_pp_error) else $error("position error bit missing");

   c_enabled: cover property ((statusWord & 16'h0237) == 16'h0237);
   c_fault: cover property (driveState == ST_FAULT_REACT ##1 driveState == ST_FAULT);
   c_recover: cover property (driveState == ST_FAULT ##1 driveState == ST_ON_DISABLED);

endmodule : dss_status_word

//--- common/dss_pkg.sv
// drive status word package: object indices, status bit layout, state
// codes, mode codes and sync cycle limits
// assumes a 100 MHz core clock and CiA-style operation mode numbers
package dss_pkg;

   // ==========================================================
   // object indices
   localparam logic [15:0] OBJ_CONTROL_WORD = 16'h6040;
   localparam logic [15:0] OBJ_STATUS_WORD = 16'h6041;
   localparam logic [15:0] STATUS_RESET = 16'h0000;

   // ==========================================================
   // status word bit positions
   localparam int SW_READY = 0;
   localparam int SW_SWITCHED_ON = 1;
   localparam int SW_OP_ENABLED = 2;
   localparam int SW_FAULT = 3;
   localparam int SW_VOLTAGE = 4;
   localparam int SW_QUICK_STOP = 5;
   localparam int SW_ON_DISABLED = 6;
   localparam int SW_MODE_LO = 8;
   localparam int SW_REMOTE = 9;
   localparam int SW_ARRIVED = 10;
   localparam int SW_LIMIT = 11;
   localparam int SW_MODE_12 = 12;
   localparam int SW_MODE_13 = 13;

   // ==========================================================
   // control word bit positions
   localparam int CW_SWITCH_ON = 0;
   localparam int CW_VOLTAGE = 1;
   localparam int CW_QUICK_STOP_N = 2;
   localparam int CW_OP_ENABLE = 3;
   localparam int CW_FAULT_RESET = 7;

   // ==========================================================
   // state codes in bits 3..0
   localparam logic [3:0] CODE_OFF = 4'h0;
   localparam logic [3:0] CODE_READY = 4'h1;
   localparam logic [3:0] CODE_SWITCHED_ON = 4'h3;
   localparam logic [3:0] CODE_OP_ENABLED = 4'h7;
   localparam logic [3:0] CODE_FAULT_REACT = 4'hf;
   localparam logic [3:0] CODE_FAULT = 4'h8;

   // ==========================================================
   // operation modes
   localparam logic [7:0] MODE_PP = 8'h01;
   localparam logic [7:0] MODE_PV = 8'h03;
   localparam logic [7:0] MODE_PT = 8'h04;
   localparam logic [7:0] MODE_HM = 8'h06;
   localparam logic [7:0] MODE_CSP = 8'h08;
   localparam logic [7:0] MODE_CSV = 8'h09;
   localparam logic [7:0] MODE_CST = 8'h0a;

   // ==========================================================
   // sync cycle timing
   localparam int CLK_HZ = 100_000_000;
   localparam int US_NS = 1000;
   localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * US_NS / 1000;
   localparam int SYNC_MIN_US = 125;
   localparam int SYNC_MAX_US = 20000;
   localparam int SYNC_NOM_MIN_US = 250;
   localparam int SYNC_NOM_MAX_US = 10000;
   localparam int SYNC_GRID_US = 250;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      ST_NOT_READY, ST_ON_DISABLED, ST_READY, ST_SWITCHED_ON,
      ST_OP_ENABLED, ST_QUICK_STOP, ST_FAULT_REACT, ST_FAULT
   } dss_state_t;

   typedef struct packed {
      logic posErrTooLarge;
      logic abnormalStop;
      logic velocityZero;
      logic homingDone;
      logic homingError;
      logic followingValid;
   } dss_mode_flags_t;

   typedef struct packed {
      logic measured;
      logic inRange;
      logic nominal;
      logic onGrid;
   } dss_sync_status_t;

endpackage : dss_pkg

//--- logic/dss_sync_monitor.sv
// sync cycle monitor: measures time between sync pulses in microseconds
// assumes syncPulse is a one-cycle pulse synchronous to core_clk
`timescale 1ns/1ps
module dss_sync_monitor #(
   parameter int MIN_US = dss_pkg::SYNC_MIN_US,
   parameter int MAX_US = dss_pkg::SYNC_MAX_US
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // sync event
   input wire logic syncPulse,
   // measured result
   output dss_pkg::dss_sync_status_t syncStatus
);
   import dss_pkg::*;

   logic [6:0] tickCnt_reg;
   logic [14:0] usCnt_reg;
   logic [7:0] gridCnt_reg;
   logic seen_reg;
   dss_sync_status_t status_reg;

   // ==========================================================
   // microsecond tick divider and period measure
   wire tick = (tickCnt_reg == 7'(TICK_CYCLES - 1));
   wire usSat = (usCnt_reg > 15'(MAX_US));
   wire inRangeNow = (usCnt_reg >= 15'(MIN_US)) && !usSat;
   wire nominalNow = (usCnt_reg >= 15'(SYNC_NOM_MIN_US)) &&
                     (usCnt_reg <= 15'(SYNC_NOM_MAX_US));
   wire onGridNow = (gridCnt_reg == 8'h00) && nominalNow;

   // tick counter; restarts at one so the pulse cycle itself counts and
   // a period of whole microseconds measures exactly, not one short
   always_ff @(posedge core_clk) begin
      if (!rstn) tickCnt_reg <= 7'h00;
      else if (syncPulse) tickCnt_reg <= 7'h01;
      else tickCnt_reg <= tick ? 7'h00 : tickCnt_reg + 7'h01;
   end

   // period counters, cleared on every sync pulse
   always_ff @(posedge core_clk) begin
      if (!rstn || syncPulse) begin
         usCnt_reg <= 15'h0000;
         gridCnt_reg <= 8'h00;
      end else if (tick && !usSat) begin
         usCnt_reg <= usCnt_reg + 15'h0001;
         gridCnt_reg <= (gridCnt_reg == 8'(SYNC_GRID_US - 1)) ? 8'h00 : gridCnt_reg + 8'h01;
      end
   end

   // result latched at each pulse after the first; timeout drops range
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         seen_reg <= 1'b0;
         status_reg <= '0;
      end else if (syncPulse) begin
         seen_reg <= 1'b1;
         status_reg <= '{measured: seen_reg, inRange: seen_reg && inRangeNow,
                         nominal: seen_reg && nominalNow, onGrid: seen_reg && onGridNow};
      end else if (usSat) begin
         status_reg.inRange <= 1'b0;
         status_reg.nominal <= 1'b0;
         status_reg.onGrid <= 1'b0;
      end
   end
   assign syncStatus = status_reg;

   // ==========================================================
   // checks
   property p_short_period;
      @(posedge core_clk) disable iff (!rstn)
         syncPulse && usCnt_reg < 15'(MIN_US) |=> !syncStatus.inRange;
   endproperty
   a_short_period: assert property (p_short_period) else $error("short period in range");

   property p_long_period;
      @(posedge core_clk) disable iff (!rstn)
         usSat |=> !syncStatus.inRange;
   endproperty
   a_long_period: assert property (p_long_period) else $error("long period in range");

   c_in_range: cover property (@(posedge core_clk) disable iff (!rstn) syncStatus.onGrid);

endmodule : dss_sync_monitor

//--- bench/dss_master_model.sv
// fieldbus master model: control word frames, status polling, sync
// assumes the drive registers its status word on core_clk
`timescale 1ns/1ps
module dss_master_model (
   // clock
   core_clk,
   // frame towards the drive
   controlValid,
   controlWord,
   syncPulse,
   // frame from the drive
   statusWord
);
   input wire logic core_clk;
   output logic controlValid;
   output logic [15:0] controlWord;
   output logic syncPulse;
   input wire logic [15:0] statusWord;
   import dss_pkg::*;

   // ==========================================================
   // idle levels
   initial begin
      controlValid = 1'b0;
      controlWord = 16'hffff;
      syncPulse = 1'b0;
   end

   // one frame; word inverted once the frame is gone
   task automatic sendCw(input logic [15:0] cw);
      @(posedge core_clk);
      controlValid <= 1'b1;
      controlWord <= cw;
      @(posedge core_clk);
      controlValid <= 1'b0;
      controlWord <= ~cw;
   endtask : sendCw

   // enable step: write, then poll the masked status word
   task automatic enableStep(input logic [15:0] cw, input logic [15:0] mask, output bit ok);
      sendCw(cw);
      ok = 1'b0;
      for (int i = 0; i < 20 && !ok; i++) begin
         @(posedge core_clk);
         #1;
         ok = ((statusWord & mask) === mask);
      end
   endtask : enableStep

   // sync pulse after n idle cycles; n+1 cycles apart
   task automatic syncAfter(input int n);
      repeat (n) @(posedge core_clk);
      syncPulse <= 1'b1;
      @(posedge core_clk);
      syncPulse <= 1'b0;
   endtask : syncAfter
endmodule : dss_master_model

//--- bench/test_dss_status_word.sv
// self-checking bench for the drive status word block
// assumes dss_pkg is compiled first and the master model beside it
`timescale 1ns/1ps
module test_dss_status_word;
   import dss_pkg::*;
   // ==========================================================
   // stimulus and observed signals
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic controlValid, syncPulse;
   logic [15:0] controlWord, statusWord;
   logic [7:0] opMode;
   logic faultActive;
   logic voltagePresent;
   logic posLimitActive;
   logic posArrived;
   logic remoteControl;
   dss_mode_flags_t modeFlags;
   dss_state_t driveState;
   dss_sync_status_t syncStatus;
   int failures = 0;
   int cmpCount = 0;
   bit ok;

   // 100 MHz clock
   always #5 core_clk = ~core_clk;

   // design and master
   dss_status_word dss_status_word_inst (.core_clk(core_clk), .rstn(rstn),
      .controlValid(controlValid), .controlWord(controlWord), .opMode(opMode),
      .faultActive(faultActive), .voltagePresent(voltagePresent),
      .posLimitActive(posLimitActive), .posArrived(posArrived),
      .remoteControl(remoteControl), .modeFlags(modeFlags), .syncPulse(syncPulse),
      .statusWord(statusWord), .driveState(driveState), .syncStatus(syncStatus));
   dss_master_model dss_master_model_inst (.core_clk(core_clk),
      .controlValid(controlValid), .controlWord(controlWord),
      .syncPulse(syncPulse), .statusWord(statusWord));

   // ==========================================================
   // helpers
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmpCount, failures);
      if (failures == 0 && cmpCount > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : settle

   task automatic waitState(input dss_state_t s);
      #1;
      for (int i = 0; i < 10 && driveState !== s; i++) settle(1);
      if (driveState !== s) begin
         failures++;
         conclude();
      end
   endtask : waitState

   // expected mode bits 13, 12 and 8
   function automatic logic [15:0] modeExp(input logic [7:0] m, input dss_mode_flags_t f);
      logic [15:0] e;
      e = '0;
      e[13] = (m == MODE_PP) ? f.posErrTooLarge : (m == MODE_HM) ? f.homingError : 1'b0;
      e[12] = (m == MODE_PV) ? f.velocityZero : (m == MODE_HM) ? f.homingDone :
         (m inside {MODE_CSP, MODE_CSV, MODE_CST}) ? f.followingValid : 1'b0;
      e[8] = (m inside {MODE_PP, MODE_HM, MODE_CSP}) ? f.abnormalStop : 1'b0;
      return e;
   endfunction : modeExp

   // ==========================================================
   // scenarios
   task automatic testReset;
      @(posedge core_clk);
      opMode <= MODE_PT;
      faultActive <= 1'b0;
      voltagePresent <= 1'b1;
      posLimitActive <= 1'b0;
      posArrived <= 1'b0;
      remoteControl <= 1'b1;
      modeFlags <= '0;
      settle(18);
      check("reset word", statusWord, 16'h0000);
      @(posedge core_clk);
      rstn <= 1'b1;
      settle(3);
      check("disabled word", statusWord, 16'h0250);
      dss_master_model_inst.sendCw(16'h000f);
      settle(3);
      check("illegal cmd", statusWord, 16'h0250);
   endtask : testReset

   task automatic testEnable;
      logic [15:0] cws[4] = '{16'h0000, 16'h0006, 16'h0007, 16'h000f};
      logic [15:0] masks[4] = '{16'h0250, 16'h0231, 16'h0233, 16'h0237};
      for (int i = 0; i < 4; i++) begin
         dss_master_model_inst.enableStep(cws[i], masks[i], ok);
         if (!ok) begin
            failures++;
            conclude();
         end
         check("enable step", statusWord, masks[i]);
      end
      check("enabled state", 16'(driveState), 16'(ST_OP_ENABLED));
   endtask : testEnable

   task automatic testQuickStop;
      dss_master_model_inst.sendCw(16'h0002);
      waitState(ST_QUICK_STOP);
      check("quick stop", statusWord, 16'h0217);
      dss_master_model_inst.sendCw(16'h000f);
      waitState(ST_OP_ENABLED);
      check("reenabled", statusWord, 16'h0237);
   endtask : testQuickStop

   task automatic testFlags;
      @(posedge core_clk);
      posLimitActive <= 1'b1;
      settle(2);
      check("limit bit", statusWord, 16'h0a37);
      @(posedge core_clk);
      posLimitActive <= 1'b0;
      posArrived <= 1'b1;
      remoteControl <= 1'b0;
      voltagePresent <= 1'b0;
      settle(2);
      check("arrival bit", statusWord, 16'h0427);
      @(posedge core_clk);
      posArrived <= 1'b0;
      remoteControl <= 1'b1;
      voltagePresent <= 1'b1;
      settle(2);
      check("voltage bit", statusWord, 16'h0237);
   endtask : testFlags

   task automatic testModes;
      logic [7:0] modes[7] = '{MODE_PP, MODE_PV, MODE_PT, MODE_HM, MODE_CSP, MODE_CSV, MODE_CST};
      for (int m = 0; m < 7; m++) begin
         for (int f = 0; f < 6; f++) begin
            @(posedge core_clk);
            opMode <= modes[m];
            modeFlags <= dss_mode_flags_t'(6'h01 << f);
            settle(2);
            check("mode bits", statusWord & 16'h3100, modeExp(modes[m], modeFlags));
         end
      end
      @(posedge core_clk);
      opMode <= MODE_PT;
      modeFlags <= '0;
      settle(2);
   endtask : testModes

   task automatic testFault;
      @(posedge core_clk);
      faultActive <= 1'b1;
      waitState(ST_FAULT_REACT);
      check("reaction", statusWord, 16'h021f);
      settle(1);
      check("fault", statusWord, 16'h0218);
      dss_master_model_inst.sendCw(16'h0080);
      settle(3);
      check("reset refused", statusWord, 16'h0218);
      @(posedge core_clk);
      faultActive <= 1'b0;
      dss_master_model_inst.sendCw(16'h0000);
      dss_master_model_inst.sendCw(16'h0080);
      waitState(ST_ON_DISABLED);
      check("fault reset", statusWord, 16'h0250);
   endtask : testFault

   task automatic testSync;
      dss_master_model_inst.syncAfter(5);
      dss_master_model_inst.syncAfter(24999);
      settle(3);
      check("sync 250us", 16'(syncStatus), 16'h000f);
      dss_master_model_inst.syncAfter(12499);
      settle(3);
      check("sync 125us", 16'(syncStatus), 16'h000c);
   endtask : testSync

   // main sequence
   initial begin
      testReset();
      testEnable();
      testQuickStop();
      testFlags();
      testModes();
      testFault();
      testSync();
      conclude();
   end
endmodule : test_dss_status_word
